// [sac_adc_ctrl.v]
/*
  Control, status and result logic of an eight-channel ten-bit
  successive-approximation converter, reached over AXI4-Lite.
  Assumes an external analog comparator whose result cmpIn is
  synchronous to clk, a DAC driven from dacCode and a sample switch driven from sampleHold.
*/
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_adc_ctrl (
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire [`SAC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SAC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmpIn,
  output reg anaPowerEn,
  output reg [2:0] anaChanSel,
  output reg [9:0] dacCode,
  output reg sampleHold,
  output reg refClk,
  output reg [7:0] pinAltFunc,
  output reg [7:0] pinAnalogConnect,
  output reg irq
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SAMPLE = 3'h2;
  localparam [2:0] ST_CONV = 3'h4;

  localparam [`SAC_ADDR_W-1:0] ADDR_PRESCALER = {2'h0, `SAC_IDX_PRESCALER, 2'h0};
  localparam [`SAC_ADDR_W-1:0] ADDR_RESULT_LO = {2'h0, `SAC_IDX_RESULT_LO, 2'h0};
  localparam [`SAC_ADDR_W-1:0] ADDR_RESULT_HI = {2'h0, `SAC_IDX_RESULT_HI, 2'h0};
  localparam [`SAC_ADDR_W-1:0] ADDR_CONTROL = {2'h0, `SAC_IDX_CONTROL, 2'h0};
  localparam [`SAC_ADDR_W-1:0] ADDR_PIN_PRI = {2'h0, `SAC_IDX_PIN_PRI, 2'h0};
  localparam [`SAC_ADDR_W-1:0] ADDR_PIN_SEC = {2'h0, `SAC_IDX_PIN_SEC, 2'h0};
  localparam integer SAMPLE_TICKS = `SAC_SAMPLE_TICKS;
  localparam [4:0] SAMPLE_LAST = SAMPLE_TICKS[4:0] - 5'h01;

  // Software-visible state
  reg [7:0] prescaler_q;
  reg [7:0] resultLo_q;
  reg [1:0] resultHi_q;
  reg irqFlag_q;
  reg irqEn_q;
  reg powerEn_q;
  reg [2:0] chanSel_q;
  reg startBit_q;
  reg doneBit_q;
  reg [7:0] pinPri_q;
  reg [7:0] pinSec_q;

  // Sequencer state
  reg [2:0] state_q;
  reg [4:0] phaseCnt_q;
  reg [3:0] bitIdx_q;
  reg [9:0] sar_q;
  reg [2:0] divCnt_q;

  // Bus decode
  wire wrFire = s_axi_awready && s_axi_wready;
  wire rdFire = s_axi_arready;
  wire lane0 = s_axi_wstrb[0];
  wire [7:0] wByte = s_axi_wdata[7:0];
  wire wrPrescaler = wrFire && lane0 && (s_axi_awaddr == ADDR_PRESCALER);
  wire wrControl = wrFire && lane0 && (s_axi_awaddr == ADDR_CONTROL);
  wire wrPinPri = wrFire && lane0 && (s_axi_awaddr == ADDR_PIN_PRI);
  wire wrPinSec = wrFire && lane0 && (s_axi_awaddr == ADDR_PIN_SEC);
  reg wrMapped;
  reg rdMapped;
  reg [7:0] rdByte;

  // Converter control decisions
  wire refEn = prescaler_q[`SAC_PS_REF_EN];
  wire [2:0] divSel = prescaler_q[`SAC_PS_DIV_HI:`SAC_PS_DIV_LO];
  wire running = powerEn_q && refEn;
  wire refTick = running && (divCnt_q == divSel) && !refClk;
  wire startReq = wrControl && wByte[`SAC_CTL_START];
  wire startFire = startReq && running && (state_q == ST_IDLE);
  wire bitKeep = cmpIn;
  reg [9:0] sarFinal;
  wire convDone = (state_q == ST_CONV) && refTick && (bitIdx_q == 4'h0);
  wire convBegin = (state_q == ST_SAMPLE) && refTick && (phaseCnt_q == SAMPLE_LAST);
  reg doneBit_d;
  reg irqFlag_d;
  reg irqEn_d;

  always @*
  begin
    sarFinal = sar_q;
    if (!bitKeep)
      sarFinal[bitIdx_q] = 1'b0;
  end

  // Set wins over a software clear in the same cycle
  always @*
  begin
    doneBit_d = doneBit_q;
    if (convBegin)
      doneBit_d = 1'b0;
    if (wrControl && !wByte[`SAC_CTL_DONE])
      doneBit_d = 1'b0;
    if (convDone)
      doneBit_d = 1'b1;
  end

  always @*
  begin
    irqFlag_d = irqFlag_q;
    irqEn_d = irqEn_q;
    if (wrControl)
    begin
      irqEn_d = wByte[`SAC_CTL_IRQ_EN];
      // Software can only clear; hardware alone sets
      if (!wByte[`SAC_CTL_IRQ_FLAG])
        irqFlag_d = 1'b0;
    end
    if (doneBit_d && !doneBit_q)
      irqFlag_d = 1'b1;
  end

  always @*
  begin
    wrMapped = 1'b1;
    case (s_axi_awaddr)
      ADDR_PRESCALER: wrMapped = 1'b1;
      ADDR_RESULT_LO: wrMapped = 1'b1;
      ADDR_RESULT_HI: wrMapped = 1'b1;
      ADDR_CONTROL: wrMapped = 1'b1;
      ADDR_PIN_PRI: wrMapped = 1'b1;
      ADDR_PIN_SEC: wrMapped = 1'b1;
      default: wrMapped = 1'b0;
    endcase
  end

  always @*
  begin
    rdMapped = 1'b1;
    case (s_axi_araddr)
      ADDR_PRESCALER: rdByte = {4'h0, prescaler_q[3:0]};
      ADDR_RESULT_LO: rdByte = resultLo_q;
      ADDR_RESULT_HI: rdByte = {6'h00, resultHi_q};
      ADDR_CONTROL: rdByte = {irqFlag_q, irqEn_q, powerEn_q, chanSel_q, startBit_q, doneBit_q};
      ADDR_PIN_PRI: rdByte = pinPri_q;
      ADDR_PIN_SEC: rdByte = pinSec_q;
      default:
      begin
        rdByte = 8'h00;
        rdMapped = 1'b0;
      end
    endcase
  end

  // AXI4-Lite slave: write takes address and data together
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SAC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (!wrFire && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      if (!rdFire && !s_axi_rvalid && s_axi_arvalid)
        s_axi_arready <= 1'b1;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdMapped ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Software registers
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prescaler_q <= `SAC_RST_BYTE;
      irqFlag_q <= 1'b0;
      irqEn_q <= 1'b0;
      powerEn_q <= 1'b0;
      chanSel_q <= 3'h0;
      startBit_q <= 1'b0;
      doneBit_q <= 1'b0;
      pinPri_q <= `SAC_RST_BYTE;
      pinSec_q <= `SAC_RST_BYTE;
    end
    else if (clkEn)
    begin
      if (wrPrescaler)
        prescaler_q <= {4'h0, wByte[3:0]};
      if (wrControl)
      begin
        powerEn_q <= wByte[`SAC_CTL_POWER_EN];
        chanSel_q <= wByte[`SAC_CTL_CHAN_HI:`SAC_CTL_CHAN_LO];
      end
      // Reads as one only in the cycle after the accepted write
      startBit_q <= startFire;
      doneBit_q <= doneBit_d;
      irqFlag_q <= irqFlag_d;
      irqEn_q <= irqEn_d;
      if (wrPinPri)
        pinPri_q <= wByte;
      if (wrPinSec)
        pinSec_q <= wByte;
    end
  end

  // Reference clock divider: toggles every divSel+1 cycles
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCnt_q <= `SAC_RST_DIV;
      refClk <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!refEn)
      begin
        divCnt_q <= `SAC_RST_DIV;
        refClk <= 1'b0;
      end
      else if (divCnt_q >= divSel)
      begin
        divCnt_q <= `SAC_RST_DIV;
        refClk <= !refClk;
      end
      else
        divCnt_q <= divCnt_q + 3'h1;
    end
  end

  // Sequencer: sample phase then one SAR step per reference tick
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      phaseCnt_q <= 5'h00;
      bitIdx_q <= 4'h0;
      sar_q <= 10'h000;
      resultLo_q <= `SAC_RST_BYTE;
      resultHi_q <= 2'h0;
    end
    else if (clkEn)
    begin
      if (!running)
      begin
        state_q <= ST_IDLE;
        phaseCnt_q <= 5'h00;
        bitIdx_q <= 4'h0;
        sar_q <= 10'h000;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (startFire)
            begin
              state_q <= ST_SAMPLE;
              phaseCnt_q <= 5'h00;
            end
          end
          ST_SAMPLE:
          begin
            if (convBegin)
            begin
              state_q <= ST_CONV;
              bitIdx_q <= 4'h9;
              sar_q <= 10'h200;
            end
            else if (refTick)
              phaseCnt_q <= phaseCnt_q + 5'h01;
          end
          ST_CONV:
          begin
            if (refTick)
            begin
              if (convDone)
              begin
                resultLo_q <= sarFinal[7:0];
                resultHi_q <= sarFinal[9:8];
                state_q <= ST_SAMPLE;
                phaseCnt_q <= 5'h00;
              end
              else
              begin
                sar_q <= sarFinal | (10'h001 << (bitIdx_q - 4'h1));
                bitIdx_q <= bitIdx_q - 4'h1;
              end
            end
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Registered pin-side outputs
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      anaPowerEn <= 1'b0;
      anaChanSel <= 3'h0;
      dacCode <= 10'h000;
      sampleHold <= 1'b0;
      pinAltFunc <= 8'h00;
      pinAnalogConnect <= 8'h00;
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      anaPowerEn <= powerEn_q;
      anaChanSel <= chanSel_q;
      dacCode <= sar_q;
      sampleHold <= (state_q == ST_SAMPLE);
      pinAltFunc <= pinPri_q;
      pinAnalogConnect <= pinPri_q & pinSec_q;
      irq <= irqFlag_d && irqEn_d;
    end
  end

endmodule

// [sac_map.vh]
/*
  Register map, field positions, reset values and timing counts of the
  converter control block. Assumes inclusion by sac_adc_ctrl.v and by the bench.
*/
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// Register indices; byte address is four times the index
`define SAC_IDX_PRESCALER 8'h94
`define SAC_IDX_RESULT_LO 8'h95
`define SAC_IDX_RESULT_HI 8'h96
`define SAC_IDX_CONTROL 8'h97
`define SAC_IDX_PIN_PRI 8'h98
`define SAC_IDX_PIN_SEC 8'h99
`define SAC_ADDR_W 12

// Control register fields
`define SAC_CTL_IRQ_FLAG 7
`define SAC_CTL_IRQ_EN 6
`define SAC_CTL_POWER_EN 5
`define SAC_CTL_CHAN_HI 4
`define SAC_CTL_CHAN_LO 2
`define SAC_CTL_START 1
`define SAC_CTL_DONE 0

// Prescaler register fields
`define SAC_PS_REF_EN 3
`define SAC_PS_DIV_HI 2
`define SAC_PS_DIV_LO 0

`define SAC_RST_BYTE 8'h00
`define SAC_RST_DIV 3'h0

// Conversion time in reference clock ticks at the typical rate
`define SAC_CONV_TIME_NS 4000
`define SAC_REF_TYP_KHZ 8000
`define SAC_CONV_TICKS (`SAC_CONV_TIME_NS * `SAC_REF_TYP_KHZ / 1000000)
`define SAC_RES_BITS 10
`define SAC_SAMPLE_TICKS (`SAC_CONV_TICKS - `SAC_RES_BITS)

`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// [sac_adc_monitor.sv]
/*
  Port-level checker of the converter control block.
  Assumes binding into every sac_adc_ctrl instance.
*/
`timescale 1ns/1ps
module sac_adc_monitor (
  input logic clk,
  input logic sys_rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic anaPowerEn,
  input logic sampleHold,
  input logic irq,
  input logic [7:0] pinAltFunc,
  input logic [7:0] pinAnalogConnect
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_bans; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
  property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_idle; !anaPowerEn && !$past(anaPowerEn) |-> !sampleHold; endproperty
  // Power only follows a register write
  property p_power; $rose(anaPowerEn) |-> $past(s_axi_awready, 2); endproperty
  property p_conv; $rose(sampleHold) |-> ##[1:400] !sampleHold; endproperty
  property p_cont; $fell(sampleHold) |-> ##[1:200] (sampleHold || !anaPowerEn); endproperty
  property p_rst; $fell(sys_rst) |-> !irq && !anaPowerEn && !sampleHold && !pinAltFunc; endproperty
  property p_pins; (pinAnalogConnect & ~pinAltFunc) == 8'h00; endproperty
  a_bans: assert property (p_bans) else $error("no write answer");
  a_bdrop: assert property (p_bdrop) else $error("write answer held");
  a_rans: assert property (p_rans) else $error("no read answer");
  a_idle: assert property (p_idle) else $error("sampling while off");
  a_power: assert property (p_power) else $error("power without write");
  a_conv: assert property (p_conv) else $error("sampling too long");
  a_cont: assert property (p_cont) else $error("no next conversion");
  a_rst: assert property (p_rst) else $error("output set after reset");
  a_pins: assert property (p_pins) else $error("analog on gpio pin");
  c_irq: cover property ($rose(irq));
  c_clr: cover property ($fell(irq));
  c_cont: cover property ($fell(sampleHold) ##[1:200] sampleHold);
endmodule

bind sac_adc_ctrl sac_adc_monitor i_sac_adc_monitor (.clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .anaPowerEn, .sampleHold, .irq, .pinAltFunc,
  .pinAnalogConnect);

// [sac_cmp_model.sv]
/*
  Input mux and comparator standing in for the analog side.
  Assumes one static level per input, set by the bench.
*/
`timescale 1ns/1ps
module sac_cmp_model (
  input logic anaPowerEn,
  input logic [2:0] anaChanSel,
  input logic [9:0] dacCode,
  input logic [7:0] pinAnalogConnect,
  input logic [7:0][9:0] level,
  output logic cmpIn
);
  logic [9:0] vin;
  // Unpowered or unconnected input reads as ground
  assign vin = (anaPowerEn && pinAnalogConnect[anaChanSel]) ? level[anaChanSel] : 10'h000;
  assign cmpIn = vin >= dacCode;
endmodule

// [testbench.sv]
/*
  Self-checking bench of the converter control block.
  Assumes the block, its bound monitor and the comparator model.
*/
`timescale 1ns/1ps
`include "sac_map.vh"
`define CHK(g, e) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("wrong value at %0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench;
  localparam logic [11:0] PS = `SAC_IDX_PRESCALER << 2;
  localparam logic [11:0] LO = `SAC_IDX_RESULT_LO << 2;
  localparam logic [11:0] HI = `SAC_IDX_RESULT_HI << 2;
  localparam logic [11:0] CTL = `SAC_IDX_CONTROL << 2;
  // Calibration wait shortened so the run stays short
  localparam int CAL_CYCLES = 200;
  logic clk, sysRst, awValid, wValid, arValid;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, seed;
  logic [7:0][9:0] level;
  logic [33:0] expQ[$], mskQ[$];
  logic [9:0] res;
  wire awReady, wReady, bValid, arReady, rValid, cmpIn, powerEn, sampleHold, irq, refClk;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [2:0] chanSel;
  wire [9:0] dacCode;
  wire [7:0] altFunc, anaConn;
  int fails, samplesChecked, n, dv;

  sac_adc_ctrl i_sac_adc_ctrl (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
    .cmpIn(cmpIn), .anaPowerEn(powerEn), .anaChanSel(chanSel), .dacCode(dacCode),
    .sampleHold(sampleHold), .refClk(refClk), .pinAltFunc(altFunc),
    .pinAnalogConnect(anaConn), .irq(irq));
  sac_cmp_model i_sac_cmp_model (.anaPowerEn(powerEn), .anaChanSel(chanSel),
    .dacCode(dacCode), .pinAnalogConnect(anaConn), .level(level), .cmpIn(cmpIn));

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic guard(input int k);
    if (k > 3000)
    begin
      fails++;
      print_verdict();
    end
  endtask

  // Ready lines stay high, so each answer lasts one cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int k = 0;
    expQ.push_back({r, 32'h0});
    mskQ.push_back('1);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    do begin @(posedge clk); k++; guard(k); end while (!awReady);
    awValid <= 0;
    wValid <= 0;
    do begin @(posedge clk); k++; guard(k); end while (!bValid);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] r = 2'h0);
    int k = 0;
    expQ.push_back({r, e});
    mskQ.push_back({2'h3, m});
    arAddr <= a;
    arValid <= 1;
    do begin @(posedge clk); k++; guard(k); end while (!arReady);
    arValid <= 0;
    do begin @(posedge clk); k++; guard(k); end while (!rValid);
  endtask

  always @(posedge clk)
    if (bValid || rValid)
    begin
      logic [33:0] g, e, m;
      g = bValid ? {bResp, 32'h0} : {rResp, rData};
      e = expQ.pop_front();
      m = mskQ.pop_front();
      `CHK(g & m, e & m)
    end

  initial
  begin
    sysRst = 1;
    awValid = 0;
    wValid = 0;
    arValid = 0;
    awAddr = 0;
    arAddr = 0;
    wData = 0;
    level = '0;
    seed = 45;
    repeat (20) @(posedge clk);
    sysRst <= 0;
    @(posedge clk);
    for (int i = 0; i < 7; i++)
      rd(12'(PS + 4 * i), 0, '1, (i == 6) ? 2'h2 : 2'h0);
    wr(12'h2a0, 32'h5, 2'h2);
    $display("reset test done");
    // Reference clock still off, so start must be ignored
    wr(CTL, 32'h22);
    repeat (100) @(posedge clk);
    rd(CTL, 32'h20);
    `CHK(sampleHold, 1'b0)
    `CHK(refClk, 1'b0)
    wr(CTL, 0);
    wr(CTL + 12'h4, 32'hff);
    wr(CTL + 12'h8, 32'h7f);
    repeat (2) @(posedge clk);
    `CHK(altFunc, 8'hff)
    `CHK(anaConn, 8'h7f)
    $display("idle and pin test done");
    for (int c = 0; c < 8; c++)
    begin
      // Dividers 3, 5 and 7 keep the reference inside its range
      dv = 3 + 2 * (c % 3);
      res = 10'(rnd());
      level[c] <= res;
      if (c == 7)
        res = 10'h000;
      wr(PS, 32'(8 + dv));
      n = 0;
      do begin @(posedge clk); n++; guard(n); end while (refClk);
      do begin @(posedge clk); n++; guard(n); end while (!refClk);
      n = 0;
      do begin @(posedge clk); n++; guard(n); end while (refClk);
      do begin @(posedge clk); n++; guard(n); end while (!refClk);
      `CHK(n, 2 * (dv + 1))
      // Start is refused unless power is already on
      wr(CTL, 32'(32'h60 | c << 2));
      repeat (CAL_CYCLES) @(posedge clk);
      wr(CTL, 32'(32'h62 | c << 2));
      n = 0;
      do begin @(posedge clk); n++; guard(n); end while (!irq);
      // Clear only the flag, so the next request needs done to fall and rise
      wr(CTL, 32'(32'h61 | c << 2));
      n = 0;
      do begin @(posedge clk); n++; guard(n); end while (!irq);
      rd(LO, {24'h0, res[7:0]});
      rd(HI, {30'h0, res[9:8]});
      wr(CTL, 32'(32'ha1 | c << 2));
      `CHK(irq, 1'b0)
      wr(CTL, 32'h81);
      rd(CTL, 32'h80, 32'h80);
      wr(CTL, 0);
      rd(CTL, 0);
      $display("channel %0d test done", c);
    end
    // Let the last answer reach the checker first
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
